// ===== bench/channel_fifo_write_steering_monitor.sv
`timescale 1ns/1ps
module channel_fifo_write_steering_monitor (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, low active
  input wire logic psel, // select
  input wire logic penable, // access phase
  input wire logic pwrite, // direction
  input wire logic [14:0] paddr, // address
  input wire logic [31:0] pwdata, // write data
  input wire logic [3:0] pstrb, // strobes
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic sram_we, // store strobe
  input wire logic [15:0] sram_wdata, // stored sample
  input wire logic [31:0] fifo_active // live channels
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic fw;
  logic live;
  logic ok_s;
  assign fw = psel && pwrite && !paddr[14];
  assign live = fifo_active[paddr[12:8]];
  assign ok_s = pstrb inside {4'hF, 4'hC, 4'h3};
  a_read_refused: assert property (psel && penable && !pwrite && !paddr[14] |-> pslverr)
    else $error("fifo space read not refused");
  a_wide_wait: assert property (fw && !penable && pstrb == 4'hF && live |=> !pready)
    else $error("wide write without wait");
  a_wide_order: assert property (fw && penable && pready && pstrb == 4'hF && live |->
    sram_we && sram_wdata == pwdata[31:16] ##1 sram_we && sram_wdata == $past(pwdata[15:0]))
    else $error("wide write halves wrong");
  a_upper_store: assert property (fw && penable && pstrb == 4'hC && live |->
    pready ##1 sram_we && sram_wdata == $past(pwdata[31:16]))
    else $error("upper sample not stored");
  a_lower_store: assert property (fw && penable && pstrb == 4'h3 && live |->
    pready ##1 sram_we && sram_wdata == $past(pwdata[15:0]))
    else $error("lower sample not stored");
  a_drop_quiet: assert property (fw && penable && ok_s && !live |->
    pready && !pslverr ##1 !sram_we)
    else $error("dead channel write stored");
  a_store_cause: assert property (sram_we |-> $past(fw) && $past(penable))
    else $error("store without write");
  a_bad_strobe: assert property (fw && penable && !ok_s |-> pready && pslverr)
    else $error("odd strobes accepted");
  a_wait_once: assert property (psel && penable && !pready |=> pready)
    else $error("wait longer than one cycle");
  c_wide: cover property (fw && penable && pready && pstrb == 4'hF && live);
  c_drop: cover property (fw && penable && !live);
  c_two: cover property (sram_we ##1 sram_we);
endmodule // channel_fifo_write_steering_monitor

bind channel_fifo_write_steering channel_fifo_write_steering_monitor i_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
  .sram_we(sram_we), .sram_wdata(sram_wdata), .fifo_active(fifo_active));

// ===== bench/channel_fifo_write_steering_test.sv
`timescale 1ns/1ps
module channel_fifo_write_steering_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [14:0] paddr = 15'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr, sram_we, err;
  logic [31:0] prdata, fifo_active, rd;
  logic [15:0] sram_addr, sram_wdata;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  always #20 pclk = ~pclk;
  channel_fifo_write_steering i_channel_fifo_write_steering (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr), .sram_we(sram_we),
    .sram_addr(sram_addr), .sram_wdata(sram_wdata), .fifo_active(fifo_active));
  sram_model i_sram_model (.pclk(pclk), .sram_we(sram_we), .sram_addr(sram_addr),
    .sram_wdata(sram_wdata));
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wrap_up;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  function automatic logic [31:0] m(input int a);
    return {16'h0000, i_sram_model.mem[a]};
  endfunction
  // answer judged at the rising edge; only the bench timeout ends a wait
  task apb(input logic w, input logic [14:0] a, input logic [31:0] d, input logic [3:0] s);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task s_setup;
    chk("active_rst", fifo_active, 32'h0000_0000);
    for (int c = 1; c < 6; c += 4) begin
      apb(1'b1, 15'h4000 + 15'(4 * c), 32'h0000_0010, 4'hF);
      apb(1'b1, 15'h4080 + 15'(4 * c), 32'h0000_0012, 4'hF);
    end
    apb(1'b1, 15'h4184, 32'h0000_0026, 4'hF);
    chk("active_nomode", fifo_active, 32'h0000_0000);
    apb(1'b1, 15'h4180, 32'h0000_0001, 4'hF);
    chk("active_q0", fifo_active, 32'h0000_0006);
    apb(1'b1, 15'h4180, 32'h0000_0003, 4'hF);
    chk("active_q01", fifo_active, 32'h0000_0026);
    apb(1'b0, 15'h4014, 32'h0000_0000, 4'hF);
    chk("start_ch5", rd, 32'h0000_0010);
    apb(1'b0, 15'h4084, 32'h0000_0000, 4'hF);
    chk("end_ch1", rd, 32'h0000_0012);
    apb(1'b0, 15'h4180, 32'h0000_0000, 4'hF);
    chk("mode_rd", rd, 32'h0000_0003);
    apb(1'b0, 15'h4184, 32'h0000_0000, 4'hF);
    chk("ena_rd", rd, 32'h0000_0026);
  endtask
  task s_store;
    apb(1'b1, 15'h0100, 32'hA1A1_0000, 4'hC);
    apb(1'b1, 15'h01FE, 32'h0000_B2B2, 4'h3);
    chk("first", m(16), 32'h0000_A1A1);
    chk("second", m(17), 32'h0000_B2B2);
    apb(1'b1, 15'h0140, 32'hC3C3_D4D4, 4'hF);
    chk("wide_hi", m(18), 32'h0000_C3C3);
    chk("wide_wrap", m(16), 32'h0000_D4D4);
    apb(1'b0, 15'h4104, 32'h0000_0000, 4'hF);
    chk("ptr_ch1", rd, 32'h0000_0011);
  endtask
  task s_share;
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, 15'h0500 + 15'(2 * i), 32'h0000_5000 + i, 4'h3);
    end
    for (int i = 0; i < 3; i++) begin
      chk("shared", m(16 + i), 32'h0000_5000 + i);
    end
    apb(1'b0, 15'h4104, 32'h0000_0000, 4'hF);
    chk("ptr_ch1_kept", rd, 32'h0000_0011);
  endtask
  task s_refuse;
    int st;
    st = i_sram_model.n_st;
    apb(1'b1, 15'h0300, 32'h7777_0000, 4'hC);
    chk("drop_err", err, 1'b0);
    apb(1'b0, 15'h4188, 32'h0000_0000, 4'hF);
    chk("drops", rd, 32'h0000_0001);
    apb(1'b0, 15'h0100, 32'h0000_0000, 4'hF);
    chk("read_err", err, 1'b1);
    apb(1'b1, 15'h0100, 32'h0000_9999, 4'h1);
    chk("strb_err", err, 1'b1);
    apb(1'b1, 15'h4104, 32'h0000_0000, 4'hF);
    chk("ptr_ro_err", err, 1'b1);
    apb(1'b0, 15'h4104, 32'h0000_0000, 4'hF);
    chk("ptr_ro_kept", rd, 32'h0000_0011);
    chk("no_store", i_sram_model.n_st, st);
  endtask
  task s_leave;
    apb(1'b1, 15'h4180, 32'h0000_0002, 4'hF);
    apb(1'b1, 15'h4184, 32'h0000_0024, 4'hF);
    chk("active_left", fifo_active, 32'h0000_0020);
    apb(1'b1, 15'h0100, 32'h0000_1234, 4'h3);
    apb(1'b0, 15'h4188, 32'h0000_0000, 4'hF);
    chk("drops_left", rd, 32'h0000_0002);
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      wrap_up;
    end
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    s_setup;
    s_store;
    s_share;
    s_refuse;
    s_leave;
    wrap_up;
  end
endmodule // channel_fifo_write_steering_test

// ===== bench/sram_model.sv
`timescale 1ns/1ps
module sram_model (
  input wire logic pclk, // clock
  input wire logic sram_we, // store strobe
  input wire logic [15:0] sram_addr, // word address
  input wire logic [15:0] sram_wdata // sample
);
  // sparse store: only touched words exist, the rest read back unknown
  logic [15:0] mem [int];
  int n_st = 0;
  always @(posedge pclk) begin
    if (sram_we === 1'b1) begin
      mem[int'(sram_addr)] = sram_wdata;
      n_st++;
    end
  end
endmodule // sram_model

// ===== hw/chan_fifo_pkg.sv
package chan_fifo_pkg;
  typedef logic [31:0] word_t;
  typedef logic [15:0] smp_t;
  // channel and converter grouping
  localparam int CH_N = 32;
  localparam int QUAD_N = 8;
  localparam int CH_W = 5;
  localparam int QUAD_W = 3;
  localparam int QUAD_LSB = 2;
  // apb address layout
  localparam int ADDR_W = 15;
  localparam int CFG_BIT = 14;
  localparam int CH_LSB = 8;
  localparam int CH_MSB = 12;
  localparam int CFG_PAD_LSB = 9;
  localparam int CFG_PAD_MSB = 13;
  localparam int GRP_LSB = 7;
  localparam int GRP_MSB = 8;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 6;
  // register groups inside the config window at 0x4000
  localparam logic [1:0] GRP_START = 2'h0;
  localparam logic [1:0] GRP_END = 2'h1;
  localparam logic [1:0] GRP_PTR = 2'h2;
  localparam logic [1:0] GRP_MISC = 2'h3;
  localparam logic [4:0] IDX_MODE = 5'h00;
  localparam logic [4:0] IDX_ENA = 5'h01;
  localparam logic [4:0] IDX_DROP = 5'h02;
  // byte strobes of the sample lanes, big-endian
  localparam logic [3:0] STRB_BOTH = 4'hF;
  localparam logic [3:0] STRB_HI = 4'hC;
  localparam logic [3:0] STRB_LO = 4'h3;
  // shared sram word address width
  localparam int SRAM_AW = 16;
  typedef logic [SRAM_AW-1:0] sadr_t;
  // reset values
  localparam logic [QUAD_N-1:0] MODE_RST = 8'h00;
  localparam logic [CH_N-1:0] ENA_RST = 32'h0000_0000;
  localparam sadr_t ADR_RST = 16'h0000;
  localparam smp_t DROP_RST = 16'h0000;
  localparam smp_t DROP_ONE = 16'h0001;
  localparam sadr_t ADR_ONE = 16'h0001;
  typedef enum logic [0:0] {
    ST_FIRST = 1'b0,
    ST_SECOND = 1'b1
  } wr_state_e;
endpackage

// ===== hw/channel_fifo_write_steering.sv
`timescale 1ns/1ps
module channel_fifo_write_steering (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, low active
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [14:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic pready, // apb ready
  output logic [31:0] prdata, // apb read data
  output logic pslverr, // apb error
  output logic sram_we, // sram write strobe, one cycle per stored sample
  output logic [15:0] sram_addr, // sram word address
  output logic [15:0] sram_wdata, // sram write data
  output logic [31:0] fifo_active // per channel fifo live
);
  typedef struct packed {
    chan_fifo_pkg::wr_state_e state;
    logic [chan_fifo_pkg::QUAD_N-1:0] mode;
    logic [chan_fifo_pkg::CH_N-1:0] ena;
    chan_fifo_pkg::smp_t drop;
    chan_fifo_pkg::word_t rdata;
    logic we;
    chan_fifo_pkg::sadr_t addr;
    chan_fifo_pkg::smp_t wdata;
  } core_s;
  core_s cur_ff;
  core_s nxt_cur;

  logic setup;
  logic access;
  logic f_sel;
  logic [chan_fifo_pkg::CH_W-1:0] ch;
  logic [chan_fifo_pkg::QUAD_W-1:0] quad;
  logic ch_live;
  logic [1:0] grp;
  logic [chan_fifo_pkg::CH_W-1:0] idx;
  logic cfg_hit;
  logic cfg_ro;
  logic bad;
  logic [15:0] first_smp;
  logic [15:0] second_smp;
  logic two_smp;
  logic smp_ok;
  logic f_wr;
  logic [chan_fifo_pkg::CH_N-1:0] adv;
  logic [chan_fifo_pkg::CH_N-1:0] start_we;
  logic [chan_fifo_pkg::CH_N-1:0] end_we;
  logic [chan_fifo_pkg::CH_N-1:0][15:0] start_q;
  logic [chan_fifo_pkg::CH_N-1:0][15:0] end_q;
  logic [chan_fifo_pkg::CH_N-1:0][15:0] ptr_q;
  logic cfg_wr;
  logic misc_wr;
  logic mode_we;
  logic ena_we;
  logic drop_inc;
  chan_fifo_pkg::sadr_t cur_ptr;
  chan_fifo_pkg::word_t rd_mux;
  logic st_we;
  chan_fifo_pkg::smp_t st_smp;
  chan_fifo_pkg::wr_state_e st_next;

  assign setup = psel & ~penable;
  assign access = psel & penable;

  // fifo write space is the lower 16 KB, config sits above it
  assign f_sel = ~paddr[chan_fifo_pkg::CFG_BIT];
  assign ch = paddr[chan_fifo_pkg::CH_MSB:chan_fifo_pkg::CH_LSB];
  // low byte of the address is never looked at inside the fifo space
  assign quad = ch[chan_fifo_pkg::CH_W-1:chan_fifo_pkg::QUAD_LSB];

  // channel is live only with its converter mode and its own enable
  always_comb begin
    for (int i = 0; i < chan_fifo_pkg::CH_N; i++) begin
      fifo_active[i] = cur_ff.ena[i] & cur_ff.mode[i >> chan_fifo_pkg::QUAD_LSB];
    end
  end
  // same product as fifo_active, taken for the addressed channel only
  assign ch_live = cur_ff.ena[ch] & cur_ff.mode[quad];

  assign grp = paddr[chan_fifo_pkg::GRP_MSB:chan_fifo_pkg::GRP_LSB];
  assign idx = paddr[chan_fifo_pkg::IDX_MSB:chan_fifo_pkg::IDX_LSB];

  // config window decode; bits between window and groups must be zero
  always_comb begin
    cfg_hit = 1'b0;
    cfg_ro = 1'b0;
    if (paddr[chan_fifo_pkg::CFG_PAD_MSB:chan_fifo_pkg::CFG_PAD_LSB] == '0) begin
      case (grp)
        chan_fifo_pkg::GRP_START: cfg_hit = 1'b1;
        chan_fifo_pkg::GRP_END: cfg_hit = 1'b1;
        chan_fifo_pkg::GRP_PTR: begin
          cfg_hit = 1'b1;
          cfg_ro = 1'b1;
        end
        chan_fifo_pkg::GRP_MISC: begin
          cfg_hit = (idx == chan_fifo_pkg::IDX_MODE) | (idx == chan_fifo_pkg::IDX_ENA)
            | (idx == chan_fifo_pkg::IDX_DROP);
          cfg_ro = (idx == chan_fifo_pkg::IDX_DROP);
        end
        default: cfg_hit = 1'b0;
      endcase
    end
  end

  sample_split u_split (
    .pwdata(pwdata),
    .pstrb(pstrb),
    .first_smp(first_smp),
    .second_smp(second_smp),
    .two_smp(two_smp),
    .smp_ok(smp_ok)
  );

  // fifo space is write-only; a malformed strobe pattern is refused too
  always_comb begin
    if (f_sel) begin
      bad = ~pwrite | ~smp_ok;
    end else begin
      bad = ~cfg_hit | (pwrite & cfg_ro);
    end
  end

  assign f_wr = access & pwrite & f_sel & smp_ok & ch_live;

  // config write strobes, qualified by the completing access cycle
  assign cfg_wr = access & pwrite & ~f_sel & ~bad;
  assign misc_wr = cfg_wr & (grp == chan_fifo_pkg::GRP_MISC);
  assign mode_we = misc_wr & (idx == chan_fifo_pkg::IDX_MODE);
  assign ena_we = misc_wr & (idx == chan_fifo_pkg::IDX_ENA);
  // a dropped word counts once, whatever its width
  assign drop_inc = access & pwrite & f_sel & smp_ok & ~ch_live;
  assign cur_ptr = ptr_q[ch];

  // a two-sample word holds the bus one extra cycle for the second store
  always_comb begin
    pready = 1'b1;
    if (f_wr && two_smp && cur_ff.state == chan_fifo_pkg::ST_FIRST) begin
      pready = 1'b0;
    end
  end
  assign pslverr = access & pready & bad;

  // bound writes land at the completing edge of a legal config write
  always_comb begin
    start_we = '0;
    end_we = '0;
    if (access && pwrite && !f_sel && !bad) begin
      if (grp == chan_fifo_pkg::GRP_START) begin
        start_we[idx] = 1'b1;
      end
      if (grp == chan_fifo_pkg::GRP_END) begin
        end_we[idx] = 1'b1;
      end
    end
  end

  // each stored sample steps only the addressed channel's pointer
  always_comb begin
    adv = '0;
    if (f_wr) begin
      adv[ch] = 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < chan_fifo_pkg::CH_N; g++) begin : g_cell
      // bounds are checked against nothing but their own pointer
      fifo_ptr_cell u_cell (
        .pclk(pclk),
        .presetn(presetn),
        .start_we(start_we[g]),
        .end_we(end_we[g]),
        .wdata(pwdata[15:0]),
        .adv(adv[g]),
        .start_q(start_q[g]),
        .end_q(end_q[g]),
        .ptr_q(ptr_q[g])
      );
    end
  endgenerate

  // read mux for the config window; the fifo space has nothing to read
  always_comb begin
    rd_mux = '0;
    if (!pwrite && !f_sel) begin
      case (grp)
        chan_fifo_pkg::GRP_START: begin
          rd_mux = chan_fifo_pkg::word_t'(start_q[idx]);
        end
        chan_fifo_pkg::GRP_END: begin
          rd_mux = chan_fifo_pkg::word_t'(end_q[idx]);
        end
        chan_fifo_pkg::GRP_PTR: begin
          rd_mux = chan_fifo_pkg::word_t'(ptr_q[idx]);
        end
        chan_fifo_pkg::GRP_MISC: begin
          case (idx)
            chan_fifo_pkg::IDX_MODE: begin
              rd_mux = chan_fifo_pkg::word_t'(cur_ff.mode);
            end
            chan_fifo_pkg::IDX_ENA: begin
              rd_mux = cur_ff.ena;
            end
            chan_fifo_pkg::IDX_DROP: begin
              rd_mux = chan_fifo_pkg::word_t'(cur_ff.drop);
            end
            default: rd_mux = '0;
          endcase
        end
        default: rd_mux = '0;
      endcase
    end
  end

  // sample store path; the second sample of a wide word goes one cycle later
  always_comb begin
    st_next = cur_ff.state;
    st_we = 1'b0;
    st_smp = first_smp;
    case (cur_ff.state)
      chan_fifo_pkg::ST_FIRST: begin
        if (f_wr) begin
          st_we = 1'b1;
          st_smp = first_smp;
          if (two_smp) begin
            st_next = chan_fifo_pkg::ST_SECOND;
          end
        end
      end
      chan_fifo_pkg::ST_SECOND: begin
        // pointer has already stepped past the first sample
        st_next = chan_fifo_pkg::ST_FIRST;
        if (f_wr) begin
          st_we = 1'b1;
          st_smp = second_smp;
        end
      end
      default: begin
        st_next = chan_fifo_pkg::ST_FIRST;
      end
    endcase
  end

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.we = 1'b0;
    // read data is captured in the setup cycle so prdata leaves a flop
    if (setup) begin
      nxt_cur.rdata = rd_mux;
    end
    if (mode_we) begin
      nxt_cur.mode = pwdata[chan_fifo_pkg::QUAD_N-1:0];
    end
    if (ena_we) begin
      nxt_cur.ena = pwdata;
    end
    // dropped words are only counted, once each; counter saturates
    if (drop_inc && cur_ff.drop != '1) begin
      nxt_cur.drop = cur_ff.drop + chan_fifo_pkg::DROP_ONE;
    end
    nxt_cur.state = st_next;
    if (st_we) begin
      nxt_cur.we = 1'b1;
      nxt_cur.addr = cur_ptr;
      nxt_cur.wdata = st_smp;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff.state <= chan_fifo_pkg::ST_FIRST;
      cur_ff.mode <= chan_fifo_pkg::MODE_RST;
      cur_ff.ena <= chan_fifo_pkg::ENA_RST;
      cur_ff.drop <= chan_fifo_pkg::DROP_RST;
      cur_ff.rdata <= '0;
      cur_ff.we <= 1'b0;
      cur_ff.addr <= chan_fifo_pkg::ADR_RST;
      cur_ff.wdata <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign prdata = cur_ff.rdata;
  assign sram_we = cur_ff.we;
  assign sram_addr = cur_ff.addr;
  assign sram_wdata = cur_ff.wdata;
endmodule // channel_fifo_write_steering

// ===== hw/fifo_ptr_cell.sv
`timescale 1ns/1ps
// one channel's partition bounds and write pointer
module fifo_ptr_cell (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, low active
  input wire logic start_we, // load start bound
  input wire logic end_we, // load end bound
  input wire logic [15:0] wdata, // bound value
  input wire logic adv, // one sample stored at ptr_q
  output logic [15:0] start_q, // start bound
  output logic [15:0] end_q, // end bound
  output logic [15:0] ptr_q // next write location
);
  typedef struct packed {
    chan_fifo_pkg::sadr_t start;
    chan_fifo_pkg::sadr_t stop;
    chan_fifo_pkg::sadr_t ptr;
  } cell_s;
  cell_s cur_ff;
  cell_s nxt_cur;
  always_comb begin
    nxt_cur = cur_ff;
    if (adv) begin
      if (cur_ff.ptr == cur_ff.stop) begin
        nxt_cur.ptr = cur_ff.start;
      end else begin
        nxt_cur.ptr = cur_ff.ptr + chan_fifo_pkg::ADR_ONE;
      end
    end
    if (end_we) begin
      nxt_cur.stop = wdata;
    end
    // a new start also restarts the fifo, overriding any advance
    if (start_we) begin
      nxt_cur.start = wdata;
      nxt_cur.ptr = wdata;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff <= '{chan_fifo_pkg::ADR_RST, chan_fifo_pkg::ADR_RST, chan_fifo_pkg::ADR_RST};
    end else begin
      cur_ff <= nxt_cur;
    end
  end
  assign start_q = cur_ff.start;
  assign end_q = cur_ff.stop;
  assign ptr_q = cur_ff.ptr;
endmodule // fifo_ptr_cell

// ===== hw/sample_split.sv
`timescale 1ns/1ps
// picks the samples out of one bus word; the lower word address rides high
module sample_split (
  input wire logic [31:0] pwdata, // bus write data
  input wire logic [3:0] pstrb, // bus byte strobes
  output logic [15:0] first_smp, // sample stored first
  output logic [15:0] second_smp, // sample stored second
  output logic two_smp, // word holds two samples
  output logic smp_ok // strobes form a legal sample width
);
  always_comb begin
    first_smp = pwdata[31:16];
    second_smp = pwdata[15:0];
    two_smp = 1'b0;
    smp_ok = 1'b1;
    case (pstrb)
      chan_fifo_pkg::STRB_BOTH: two_smp = 1'b1;
      chan_fifo_pkg::STRB_HI: first_smp = pwdata[31:16];
      chan_fifo_pkg::STRB_LO: first_smp = pwdata[15:0];
      default: smp_ok = 1'b0;
    endcase
  end
endmodule // sample_split
